// File: inc/cam_pkg.sv
`default_nettype none
// ============================================================
// Shared constants for the counter array channel block.
package cam_pkg;

  // Number of compare/capture channels sharing the base counter.
  localparam int CAM_CHANNELS = 8;
  // Channels at and above this index have no capture path.
  localparam int CAM_CAPTURE_CHANNELS = 6;
  // Channels below this index answer on the low page only.
  localparam int CAM_LOW_PAGE_ONLY = 2;

  // ============================================================
  // Register addresses on the special-function register bus.
  localparam logic [7:0] CAM_CTRL_ADDR = 8'h00_D8;
  localparam logic [7:0] CAM_MODE_ADDR = 8'h00_DA;
  localparam logic [7:0] CAM_LOW_ADDR = 8'h00_EA;
  localparam logic [7:0] CAM_AUX_ADDR = 8'h00_F2;
  localparam logic [7:0] CAM_HIGH_ADDR = 8'h00_FA;
  // Page that holds channels 0 to 5, and page that holds 6 and 7.
  localparam logic [3:0] CAM_PAGE_LOW = 4'h0;
  localparam logic [3:0] CAM_PAGE_HIGH = 4'h1;

  // ============================================================
  // Reset values.
  localparam logic [7:0] CAM_REG_RESET = 8'h00_00;
  localparam logic [15:0] CAM_CNT_RESET = 16'h0000;

  // ============================================================
  // Channel mode field positions.
  localparam int CAM_MODE_DEAD = 7;
  localparam int CAM_MODE_CMP = 6;
  localparam int CAM_MODE_RISE = 5;
  localparam int CAM_MODE_FALL = 4;
  localparam int CAM_MODE_MATCH = 3;
  localparam int CAM_MODE_TOGGLE = 2;
  localparam int CAM_MODE_PWM = 1;
  localparam int CAM_MODE_IRQ = 0;
  // Writable mode bits of channels 6 and 7 (bit 5 is reserved).
  localparam logic [7:0] CAM_MODE_UPPER_MASK = 8'h00_DF;

  // ============================================================
  // Auxiliary PWM register field positions.
  localparam int CAM_AUX_RES_HI = 7;
  localparam int CAM_AUX_RES_LO = 6;
  localparam int CAM_AUX_FLAG = 3;
  localparam int CAM_AUX_INV = 2;
  localparam int CAM_AUX_EXTH = 1;
  localparam int CAM_AUX_EXTL = 0;
  // Bits kept on a write; reserved bits 5 and 4 read back as zero.
  localparam logic [7:0] CAM_AUX_WRITE_MASK = 8'h00_CF;

  // PWM resolution codes.
  typedef enum logic [1:0] {
    CAM_RES_8 = 2'b00,
    CAM_RES_10 = 2'b01,
    CAM_RES_12 = 2'b10,
    CAM_RES_16 = 2'b11
  } cam_res_e;

endpackage
`default_nettype wire

// File: design/cam_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Pin synchroniser with edge detection, one lane per channel.
module cam_pin_sync
  import cam_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Asynchronous pin levels.
  input wire logic [CAM_CHANNELS-1:0] pinIn,
  // Edge pulses, one cycle wide.
  output logic [CAM_CHANNELS-1:0] riseEdge,
  output logic [CAM_CHANNELS-1:0] fallEdge
);

  genvar i;
  generate
    for (i = 0; i < CAM_CHANNELS; i++) begin : gLane
      // Two flops for the crossing, a third holds the previous level.
      logic meta_q;
      logic sync_q;
      logic prev_q;

      // The first flop feeds only the second, never the edge logic.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          meta_q <= pinIn[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end

      // Edges are judged between the settled and the previous level.
      assign riseEdge[i] = sync_q & ~prev_q;
      assign fallEdge[i] = ~sync_q & prev_q;
    end
  endgenerate

endmodule
`default_nettype wire

// File: design/cam_pwm_cmp.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Variable-resolution PWM comparator for one channel.
module cam_pwm_cmp
  import cam_pkg::*;
(
  // Base counter now and one cycle ago.
  input wire logic [15:0] counterNow,
  input wire logic [15:0] counterPrev,
  // Channel settings.
  input wire logic [1:0] resolution,
  input wire logic [7:0] captureHigh,
  input wire logic [7:0] captureLow,
  input wire logic extHigh,
  input wire logic extLow,
  // Results.
  output logic pwmHigh,
  output logic rollover
);

  logic [16:0] mask;
  logic [16:0] cntMasked;
  logic [16:0] dutyValue;

  // The resolution picks how many low counter bits form the period.
  always_comb begin
    unique case (cam_res_e'(resolution))
      CAM_RES_8: mask = 17'h0_00FF;
      CAM_RES_10: mask = 17'h0_03FF;
      CAM_RES_12: mask = 17'h0_0FFF;
      CAM_RES_16: mask = 17'h0_FFFF;
    endcase
  end

  // The extension bit sits just above the masked field, so a set
  // extension with a zero field gives 0% and a clear one 100%.
  always_comb begin
    cntMasked = {1'b0, counterNow} & mask;
    if (cam_res_e'(resolution) == CAM_RES_8) begin
      dutyValue = {8'h00, extLow, captureLow};
    end else begin
      dutyValue = ({1'b0, captureHigh, captureLow} & mask)
        | (extHigh ? (mask + 17'h0_0001) : 17'h0_0000);
    end
  end

  // Low while the counter is below the duty value, high otherwise.
  assign pwmHigh = ~(cntMasked < dutyValue);
  // Rollover is the masked field wrapping from all ones to zero.
  assign rollover = ((({1'b0, counterPrev}) & mask) == mask) && (cntMasked == 17'h0_0000);

endmodule
`default_nettype wire

// File: design/cam_channels.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Eight compare/capture channels on one shared base counter.
module cam_channels
  import cam_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Special-function register bus.
  input wire logic [7:0] sfrAddr,
  input wire logic [3:0] sfrPage,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // Shared base counter and pair buffer enables, same clock domain.
  input wire logic [15:0] counterValue,
  input wire logic [2:0] pairBufferEnable,
  // Channel pins.
  input wire logic [CAM_CHANNELS-1:0] channelPinIn,
  output logic [CAM_CHANNELS-1:0] channelPinOut,
  output logic [CAM_CHANNELS-1:0] channelPinOe,
  // Status toward the rest of the counter array.
  output logic [2:0] deadTimeActive,
  output logic upperPairBufferEnable,
  output logic interruptRequest
);

  // ============================================================
  // Storage.
  // Mode, capture and auxiliary bytes for every channel.
  logic [7:0] modeReg_q [CAM_CHANNELS];
  logic [7:0] capLow_q [CAM_CHANNELS];
  logic [7:0] capHigh_q [CAM_CHANNELS];
  logic [7:0] auxReg_q [CAM_CHANNELS];
  // Channel flags held in the shared control register.
  logic [CAM_CAPTURE_CHANNELS-1:0] ctrlFlags_q;
  // Counter one cycle ago, for rollover detection.
  logic [15:0] counterPrev_q;
  // Registered outputs.
  logic [7:0] rdData_q;
  logic [CAM_CHANNELS-1:0] pinOut_q;
  logic [CAM_CHANNELS-1:0] pinOe_q;
  logic [2:0] deadTime_q;
  logic upperBuf_q;
  logic irq_q;

  // ============================================================
  // Per-channel wires.
  logic [CAM_CHANNELS-1:0] riseEdge;
  logic [CAM_CHANNELS-1:0] fallEdge;
  logic [CAM_CHANNELS-1:0] wrMode;
  logic [CAM_CHANNELS-1:0] wrLow;
  logic [CAM_CHANNELS-1:0] wrHigh;
  logic [CAM_CHANNELS-1:0] wrAux;
  logic [CAM_CHANNELS-1:0] captureEvt;
  logic [CAM_CHANNELS-1:0] matchEvt;
  logic [CAM_CHANNELS-1:0] allFlags;
  logic [CAM_CHANNELS-1:0] irqEnables;
  logic wrCtrl;

  // Control register writes come from page 0 only.
  assign wrCtrl = sfrWrEn && (sfrAddr == CAM_CTRL_ADDR) && (sfrPage == CAM_PAGE_LOW);

  // ============================================================
  // Pin synchroniser and edge detector.
  cam_pin_sync uSync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pinIn(channelPinIn),
    .riseEdge(riseEdge),
    .fallEdge(fallEdge)
  );

  // Previous counter value, compared against the present one.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      counterPrev_q <= CAM_CNT_RESET;
    end else begin
      counterPrev_q <= counterValue;
    end
  end

  // ============================================================
  // Channel slices.
  genvar i;
  generate
    for (i = 0; i < CAM_CHANNELS; i++) begin : gChan
      // Local slot on its page, and which pages the slot answers on.
      localparam int SLOT = (i < CAM_CAPTURE_CHANNELS) ? i : i - CAM_CAPTURE_CHANNELS;
      localparam bit HAS_CAPTURE = (i < CAM_CAPTURE_CHANNELS);
      logic pageHit;
      logic compareEqual;
      logic equalPrev_q;
      logic toggle_q;
      logic pwmHigh;
      logic rollover;
      logic pwmMode;
      logic outLevel;
      logic reload8;

      // Channels 0 and 1 sit on page 0 only, 2 to 5 on every page,
      // and 6 and 7 reuse the first two slots on page 1.
      if (i < CAM_LOW_PAGE_ONLY) begin : gPageLow
        assign pageHit = (sfrPage == CAM_PAGE_LOW);
      end else if (HAS_CAPTURE) begin : gPageAll
        assign pageHit = 1'b1;
      end else begin : gPageHigh
        assign pageHit = (sfrPage == CAM_PAGE_HIGH);
      end

      assign wrMode[i] = sfrWrEn && pageHit && (sfrAddr == 8'(CAM_MODE_ADDR + SLOT));
      assign wrLow[i] = sfrWrEn && pageHit && (sfrAddr == 8'(CAM_LOW_ADDR + SLOT));
      assign wrHigh[i] = sfrWrEn && pageHit && (sfrAddr == 8'(CAM_HIGH_ADDR + SLOT));
      assign wrAux[i] = sfrWrEn && pageHit && (sfrAddr == 8'(CAM_AUX_ADDR + SLOT));

      // PWM runs only with both the comparator and modulator enabled.
      assign pwmMode = modeReg_q[i][CAM_MODE_PWM] & modeReg_q[i][CAM_MODE_CMP];
      // In 8-bit PWM the duty bytes reload when the low counter byte wraps.
      assign reload8 = pwmMode && rollover
        && (auxReg_q[i][CAM_AUX_RES_HI:CAM_AUX_RES_LO] == CAM_RES_8);

      // Capture on the enabled edge or edges; channels 6 and 7 have
      // no capture path at all, whatever their bit 4 says.
      if (HAS_CAPTURE) begin : gCap
        assign captureEvt[i] = (modeReg_q[i][CAM_MODE_RISE] & riseEdge[i])
          | (modeReg_q[i][CAM_MODE_FALL] & fallEdge[i]);
      end else begin : gNoCap
        assign captureEvt[i] = 1'b0;
      end

      // The comparator only works while mode bit 6 is set.
      assign compareEqual = modeReg_q[i][CAM_MODE_CMP]
        && (counterValue == {capHigh_q[i], capLow_q[i]});
      // A match is the first cycle of equality, so a stopped counter
      // does not keep re-firing the toggle.
      assign matchEvt[i] = compareEqual & ~equalPrev_q & ~pwmMode;

      // Equality history for match edge detection.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          equalPrev_q <= 1'b0;
        end else begin
          equalPrev_q <= compareEqual;
        end
      end

      cam_pwm_cmp uPwm (
        .counterNow(counterValue),
        .counterPrev(counterPrev_q),
        .resolution(auxReg_q[i][CAM_AUX_RES_HI:CAM_AUX_RES_LO]),
        .captureHigh(capHigh_q[i]),
        .captureLow(capLow_q[i]),
        .extHigh(auxReg_q[i][CAM_AUX_EXTH]),
        .extLow(auxReg_q[i][CAM_AUX_EXTL]),
        .pwmHigh(pwmHigh),
        .rollover(rollover)
      );

      // Mode register; reserved bit 5 of channels 6 and 7 stays zero.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          modeReg_q[i] <= CAM_REG_RESET;
        end else if (wrMode[i]) begin
          if (HAS_CAPTURE) begin
            modeReg_q[i] <= sfrWrData;
          end else begin
            modeReg_q[i] <= sfrWrData & CAM_MODE_UPPER_MASK;
          end
        end
      end

      // Low byte: capture wins over a software write in the same
      // cycle so that a timestamp is never lost. In 8-bit PWM the low
      // byte and its extension reload from the high pair on rollover,
      // which lets software change duty without a glitch.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          capLow_q[i] <= CAM_REG_RESET;
        end else if (captureEvt[i]) begin
          capLow_q[i] <= counterValue[7:0];
        end else if (reload8) begin
          capLow_q[i] <= capHigh_q[i];
        end else if (wrLow[i]) begin
          capLow_q[i] <= sfrWrData;
        end
      end

      // High byte, same priority as the low byte.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          capHigh_q[i] <= CAM_REG_RESET;
        end else if (captureEvt[i]) begin
          capHigh_q[i] <= counterValue[15:8];
        end else if (wrHigh[i]) begin
          capHigh_q[i] <= sfrWrData;
        end
      end

      // Auxiliary register. Reserved bits are dropped on a write. The
      // match flag of channels 6 and 7 lives in bit 3; a hardware match
      // in the cycle of a clearing write still sets it.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          auxReg_q[i] <= CAM_REG_RESET;
        end else begin
          if (wrAux[i]) begin
            auxReg_q[i] <= sfrWrData & CAM_AUX_WRITE_MASK;
          end
          if (reload8) begin
            auxReg_q[i][CAM_AUX_EXTL] <= auxReg_q[i][CAM_AUX_EXTH];
          end
          if (HAS_CAPTURE) begin
            auxReg_q[i][CAM_AUX_FLAG] <= 1'b0;
          end else if (matchEvt[i] && modeReg_q[i][CAM_MODE_MATCH]) begin
            auxReg_q[i][CAM_AUX_FLAG] <= 1'b1;
          end
        end
      end

      // Toggle state flips on each match while toggle control is on.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          toggle_q <= 1'b0;
        end else if (matchEvt[i] && modeReg_q[i][CAM_MODE_TOGGLE]) begin
          toggle_q <= ~toggle_q;
        end
      end

      // Compare output before the pin, inverted by auxiliary bit 2.
      assign outLevel = (pwmMode ? pwmHigh : toggle_q) ^ auxReg_q[i][CAM_AUX_INV];

      // The pin is driven only in PWM or toggle output modes; it is an
      // input otherwise so that capture can watch an outside signal.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          pinOut_q[i] <= 1'b0;
          pinOe_q[i] <= 1'b0;
        end else begin
          pinOut_q[i] <= outLevel;
          pinOe_q[i] <= pwmMode
            | (modeReg_q[i][CAM_MODE_TOGGLE] & modeReg_q[i][CAM_MODE_CMP]);
        end
      end

      assign irqEnables[i] = modeReg_q[i][CAM_MODE_IRQ];
      if (HAS_CAPTURE) begin : gFlagLow
        assign allFlags[i] = ctrlFlags_q[i];
      end else begin : gFlagHigh
        assign allFlags[i] = auxReg_q[i][CAM_AUX_FLAG];
      end
    end

    // Shared control register flags for channels 0 to 5. A write
    // loads the bit, but a capture or match in the same cycle wins.
    for (i = 0; i < CAM_CAPTURE_CHANNELS; i++) begin : gFlag
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          ctrlFlags_q[i] <= 1'b0;
        end else if (captureEvt[i] || (matchEvt[i] && modeReg_q[i][CAM_MODE_MATCH])) begin
          ctrlFlags_q[i] <= 1'b1;
        end else if (wrCtrl) begin
          ctrlFlags_q[i] <= sfrWrData[i];
        end
      end
    end

    // Dead time applies only to even channels of a buffered pair.
    for (i = 0; i < 3; i++) begin : gDead
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          deadTime_q[i] <= 1'b0;
        end else begin
          deadTime_q[i] <= modeReg_q[2*i][CAM_MODE_DEAD] & pairBufferEnable[i]
            & modeReg_q[2*i][CAM_MODE_PWM];
        end
      end
    end
  endgenerate

  // ============================================================
  // Interrupt request and pair buffer status.
  // A flag raises the request only while its enable bit is set.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
      upperBuf_q <= 1'b0;
    end else begin
      irq_q <= |(allFlags & irqEnables);
      upperBuf_q <= modeReg_q[CAM_CAPTURE_CHANNELS][CAM_MODE_DEAD];
    end
  end

  // ============================================================
  // Read path.
  // Read data is captured on the read strobe and held until the
  // next one; unmapped addresses read as zero.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdData_q <= CAM_REG_RESET;
    end else if (sfrRdEn) begin
      rdData_q <= CAM_REG_RESET;
      if (sfrAddr == CAM_CTRL_ADDR && sfrPage == CAM_PAGE_LOW) begin
        rdData_q <= {2'b00, ctrlFlags_q};
      end
      for (int c = 0; c < CAM_CHANNELS; c++) begin
        if (((c < CAM_LOW_PAGE_ONLY) && sfrPage == CAM_PAGE_LOW)
            || ((c >= CAM_LOW_PAGE_ONLY) && (c < CAM_CAPTURE_CHANNELS))
            || ((c >= CAM_CAPTURE_CHANNELS) && sfrPage == CAM_PAGE_HIGH)) begin
          if (sfrAddr == 8'(CAM_MODE_ADDR + ((c < CAM_CAPTURE_CHANNELS) ? c : c - 6))) begin
            rdData_q <= modeReg_q[c];
          end
          if (sfrAddr == 8'(CAM_LOW_ADDR + ((c < CAM_CAPTURE_CHANNELS) ? c : c - 6))) begin
            rdData_q <= capLow_q[c];
          end
          if (sfrAddr == 8'(CAM_HIGH_ADDR + ((c < CAM_CAPTURE_CHANNELS) ? c : c - 6))) begin
            rdData_q <= capHigh_q[c];
          end
          if (sfrAddr == 8'(CAM_AUX_ADDR + ((c < CAM_CAPTURE_CHANNELS) ? c : c - 6))) begin
            rdData_q <= auxReg_q[c];
          end
        end
      end
    end
  end

  // ============================================================
  // Outputs, all straight from flops.
  assign sfrRdData = rdData_q;
  assign channelPinOut = pinOut_q;
  assign channelPinOe = pinOe_q;
  assign deadTimeActive = deadTime_q;
  assign upperPairBufferEnable = upperBuf_q;
  assign interruptRequest = irq_q;

endmodule
`default_nettype wire

// File: sim/cam_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checks for the channel block, bound into its top module.
module cam_asserts
  import cam_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Register bus.
  input wire logic [7:0] sfrAddr,
  input wire logic [3:0] sfrPage,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  // Status and pins.
  input wire logic [2:0] pairBufferEnable,
  input wire logic [CAM_CHANNELS-1:0] channelPinOut,
  input wire logic [CAM_CHANNELS-1:0] channelPinOe,
  input wire logic [2:0] deadTimeActive,
  input wire logic interruptRequest
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // A mode write to channel 0, then after a quiet cycle a read of it.
  sequence modeWrite;
    sfrWrEn && sfrPage == CAM_PAGE_LOW && sfrAddr == CAM_MODE_ADDR;
  endsequence
  sequence modeRead;
    sfrRdEn && !sfrWrEn && sfrPage == CAM_PAGE_LOW && sfrAddr == CAM_MODE_ADDR;
  endsequence
  AST_RESET_QUIET: assert property (
    $fell(sys_rst) |-> channelPinOe == 8'h00 && channelPinOut == 8'h00 && !interruptRequest)
    else $error("outputs busy after reset");
  AST_MODE_READBACK: assert property (
    modeWrite ##1 !sfrWrEn ##1 modeRead |=> sfrRdData == $past(sfrWrData, 3))
    else $error("mode byte read back wrong");
  AST_UNMAPPED_ZERO: assert property (
    sfrRdEn && sfrAddr == 8'hE0 |=> sfrRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_UPPER_RISE_RESERVED: assert property (
    sfrRdEn && sfrPage == CAM_PAGE_HIGH && sfrAddr inside {8'hDA, 8'hDB} |=> !sfrRdData[5])
    else $error("reserved capture bit of channel 6 or 7 set");
  AST_AUX_RESERVED_ZERO: assert property (
    sfrRdEn && sfrAddr inside {[8'hF2:8'hF7]} |=> sfrRdData[5:4] == 2'b00)
    else $error("reserved auxiliary bits not zero");
  AST_CTRL_TOP_ZERO: assert property (
    sfrRdEn && sfrPage == CAM_PAGE_LOW && sfrAddr == CAM_CTRL_ADDR |=> sfrRdData[7:6] == 2'b00)
    else $error("control top bits not zero");
  AST_DEAD_NEEDS_BUFFER: assert property (
    (deadTimeActive & ~$past(pairBufferEnable)) == 3'b000)
    else $error("dead time without pair buffering");
  // Only software clears a flag, so the request may only drop after a write.
  AST_IRQ_FALL_BY_WRITE: assert property (
    $fell(interruptRequest) |-> $past(sfrWrEn) || $past(sfrWrEn, 2) || $past(sys_rst))
    else $error("interrupt dropped without a write");
endmodule
bind cam_channels cam_asserts u_asserts (
  .clock, .sys_rst, .sfrAddr, .sfrPage, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
  .pairBufferEnable, .channelPinOut, .channelPinOe, .deadTimeActive, .interruptRequest
);
`default_nettype wire

// File: sim/cam_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Far side of the channel pins: an external source and a duty meter.
module cam_pin_model
  import cam_pkg::*;
#(
  parameter int WATCH = 2
)
(
  // Clock.
  input wire logic clock,
  // Design side of the pins and the level the source wants.
  input wire logic [CAM_CHANNELS-1:0] pinOut,
  input wire logic [CAM_CHANNELS-1:0] pinOe,
  input wire logic [CAM_CHANNELS-1:0] extLevel,
  // Meter control, wire levels and high-cycle count.
  input wire logic meterClear,
  output logic [CAM_CHANNELS-1:0] pinLevel,
  output logic [15:0] highCount
);
  // A driving channel owns its wire; the source has it otherwise.
  assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
  // Counting high cycles of one pin gives its duty over a whole period.
  always_ff @(posedge clock) begin
    if (meterClear) begin
      highCount <= 16'h0000;
    end else if (pinLevel[WATCH]) begin
      highCount <= highCount + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: sim/cam_channels_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin \
  totalChecks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("ERROR at %0t got %h expected %h", $time, (got), (exp)); \
  end \
end
// ==========
// Register-level bench for the channel block.
module cam_channels_tb
  import cam_pkg::*;
;
  localparam logic [3:0] PG0 = CAM_PAGE_LOW;
  localparam logic [3:0] PG1 = CAM_PAGE_HIGH;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic [3:0] sfrPage = 4'h0;
  logic sfrWrEn = 1'b0;
  logic sfrRdEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic [7:0] sfrRdData;
  logic [15:0] counterValue = 16'h0000;
  logic [2:0] pairBufferEnable = 3'h0;
  logic [7:0] extLevel = 8'h00;
  logic [7:0] pinLevel;
  logic [7:0] pinOut;
  logic [7:0] pinOe;
  logic [2:0] deadTimeActive;
  logic upperPairBufferEnable;
  logic interruptRequest;
  logic meterClear = 1'b0;
  logic [15:0] highCount;
  logic [15:0] capExp = 16'h0000;
  int errors = 0;
  int totalChecks = 0;
  // Step tables: reset reads, capture modes with expected hits, PWM cases.
  logic [7:0] resetAddr [5] = '{CAM_CTRL_ADDR, CAM_MODE_ADDR, CAM_LOW_ADDR, CAM_AUX_ADDR,
    CAM_HIGH_ADDR};
  logic [7:0] capMode [6] = '{8'h21, 8'h21, 8'h10, 8'h10, 8'h31, 8'h30};
  logic [5:0] capHit = 6'b111001;
  logic [7:0] pwmAux [6] = '{8'h00, 8'h04, 8'h02, 8'h00, 8'h40, 8'h80};
  logic [7:0] pwmHigh [6] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h02, 8'h08};
  int pwmPer [6] = '{256, 256, 256, 256, 1024, 4096};
  logic [15:0] pwmExp [6] = '{16'h00C0, 16'h0040, 16'h0000, 16'h0100, 16'h0200, 16'h0800};

  always #12.5 clock = ~clock;

  cam_channels dut (
    .clock, .sys_rst, .sfrAddr, .sfrPage, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
    .counterValue, .pairBufferEnable, .channelPinIn(pinLevel), .channelPinOut(pinOut),
    .channelPinOe(pinOe), .deadTimeActive, .upperPairBufferEnable, .interruptRequest
  );
  cam_pin_model pins (
    .clock, .pinOut, .pinOe, .extLevel, .meterClear, .pinLevel, .highCount
  );

  // ==========
  // Bus cycles: the strobe stands for exactly one taking edge.
  task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfrPage <= pg;
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clock);
    sfrWrEn <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfrPage <= pg;
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clock);
    sfrRdEn <= 1'b0;
    @(negedge clock);
    `CHECK(sfrRdData, exp)
  endtask
  // The base counter counts up only here and is otherwise set directly, so captures see a known value.
  task automatic run(input int n);
    repeat (n) begin
      @(posedge clock);
      counterValue <= counterValue + 16'h0001;
      meterClear <= 1'b0;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic endOfTest();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (resetAddr[i]) rdChk(PG0, resetAddr[i], 8'h00);
    wr(PG0, CAM_MODE_ADDR, 8'hA5);
    rdChk(PG0, CAM_MODE_ADDR, 8'hA5);
    wr(PG0, 8'hE0, 8'hFF);
    rdChk(PG0, 8'hE0, 8'h00);
    wr(PG0, 8'hF4, 8'hCF);
    rdChk(PG0, 8'hF4, 8'hC7);
    wr(PG1, CAM_MODE_ADDR, 8'h30);
    rdChk(PG1, CAM_MODE_ADDR, 8'h10);
    // Each step flips every pin; channel 6 must never capture.
    for (int i = 0; i < 6; i++) begin
      wr(PG0, CAM_MODE_ADDR, capMode[i]);
      @(posedge clock);
      counterValue <= 16'h1200 + 16'(i);
      extLevel <= ~extLevel;
      settle(6);
      if (capHit[i]) capExp = 16'h1200 + 16'(i);
      rdChk(PG0, CAM_LOW_ADDR, capExp[7:0]);
      rdChk(PG0, CAM_HIGH_ADDR, capExp[15:8]);
      `CHECK(interruptRequest, capHit[i] & capMode[i][0])
      rdChk(PG0, CAM_CTRL_ADDR, {7'h00, capHit[i]});
      wr(PG0, CAM_CTRL_ADDR, 8'h00);
    end
    rdChk(PG1, CAM_LOW_ADDR, 8'h00);
    // Channel 1 compares at 0x0050; it matches with the comparator on and not with it off.
    wr(PG0, 8'hEB, 8'h50);
    for (int i = 0; i < 2; i++) begin
      wr(PG0, 8'hDB, (i == 0) ? 8'h4C : 8'h0C);
      @(posedge clock);
      counterValue <= 16'h0040;
      run(32);
      rdChk(PG0, CAM_CTRL_ADDR, (i == 0) ? 8'h02 : 8'h00);
      `CHECK(pinLevel[1], i == 0)
      wr(PG0, CAM_CTRL_ADDR, 8'h00);
    end
    wr(PG1, CAM_LOW_ADDR, 8'h50);
    wr(PG1, CAM_MODE_ADDR, 8'h49);
    @(posedge clock);
    counterValue <= 16'h0040;
    run(32);
    rdChk(PG1, CAM_AUX_ADDR, 8'h08);
    `CHECK(interruptRequest, 1'b1)
    wr(PG1, CAM_AUX_ADDR, 8'h00);
    rdChk(PG1, CAM_AUX_ADDR, 8'h00);
    wr(PG0, CAM_MODE_ADDR, 8'h82);
    wr(PG1, CAM_MODE_ADDR, 8'h80);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      pairBufferEnable <= 3'(i);
      settle(2);
      `CHECK(deadTimeActive, 3'(i))
    end
    `CHECK(upperPairBufferEnable, 1'b1)
    // Channel 2 PWM: settle two periods, then meter exactly one.
    wr(PG0, 8'hDC, 8'h42);
    for (int i = 0; i < 6; i++) begin
      wr(PG0, 8'hF4, pwmAux[i]);
      wr(PG0, 8'hFC, pwmHigh[i]);
      run(2 * pwmPer[i]);
      @(posedge clock);
      meterClear <= 1'b1;
      run(pwmPer[i] + 1);
      settle(0);
      `CHECK(highCount, pwmExp[i])
    end
    endOfTest();
  end

  // A hang costs a mismatch; the tests need about half this span.
  initial begin
    #1_000_000;
    errors++;
    endOfTest();
  end
endmodule
`default_nettype wire
